// *** src/css_defines.svh ***
`ifndef CSS_DEFINES_SVH
`define CSS_DEFINES_SVH

// number of slots in one scheduling cycle
`define CSS_SLOT_COUNT 3'h7
// index of slot one
`define CSS_SLOT_FIRST 3'h0
// index of slot seven
`define CSS_SLOT_LAST 3'h6
// assigned level of each slot, two bits per slot, slot one in bits 1:0
// sequence high, middle, high, low, high, middle, high
`define CSS_SLOT_LEVELS 14'h3b7b
// width of one level field
`define CSS_LEVEL_W 2
// default channel count
`define CSS_CHANNELS 32
// reset values
`define CSS_PENDING_RST 1'b0
`define CSS_GRANTED_RST 1'b0

`endif

// *** src/css_pkg.sv ***
`default_nettype none
package css_pkg;

	// channel_priority_field encoding; null disables the channel
	typedef enum logic [1:0] {
		CSS_LVL_NULL = 2'h0,
		CSS_LVL_LOW = 2'h1,
		CSS_LVL_MID = 2'h2,
		CSS_LVL_HIGH = 2'h3
	} css_level_t;

	// one-hot scheduler states
	typedef enum logic [1:0] {
		CSS_ST_IDLE = 2'h1,
		CSS_ST_BUSY = 2'h2
	} css_state_t;

endpackage
`default_nettype wire

// *** src/css_scheduler.sv ***
// Function
// - null priority disables; never grant disabled channels
// - disabling mid-thread lets thread finish normally
// - requests held while disabled, served when re-enabled
// - reset: all disabled, all requests cleared; code clears pending and grant bits, priority is input I_CHAN_PRIORITY
// - one grant bit per channel, set on grant
// - granted channel may request, not regranted until cleared
// - thread end clears level once all requesters granted
// - seven-slot cycle: four high, two middle, one low
// - slot order high middle high low high middle high
// - exactly one grant per time slot
// - one independent scheduler instance per engine
// - nothing pending and idle: restart at slot one
// - slot level served first, else passed on
// - passing order: H:M,L; M:H,L; L:H,M
// - after passing, continue with the next slot
// - lowest-numbered eligible channel wins within level
// - requests from channel logic, microcode and host
// - running thread not preempted; slot lasts thread
`timescale 1ns/1ns
`default_nettype none
`include "css_defines.svh"

module css_scheduler #(
	parameter int CHANNELS = `CSS_CHANNELS,
	parameter int CHAN_W = (CHANNELS > 1) ? $clog2(CHANNELS) : 1
) (
	input wire logic I_CLK,
	input wire logic I_ARST_N,
	input wire logic [2*CHANNELS-1:0] I_CHAN_PRIORITY,
	input wire logic [CHANNELS-1:0] I_CHAN_EVENT_REQ,
	input wire logic [CHANNELS-1:0] I_CODE_REQ,
	input wire logic [CHANNELS-1:0] I_HOST_REQ,
	input wire logic [CHANNELS-1:0] I_REQ_CLEAR,
	input wire logic I_THREAD_END,
	output logic O_GRANT,
	output logic [CHAN_W-1:0] O_GRANT_CHAN,
	output logic O_BUSY,
	output logic [2:0] O_SLOT,
	output logic [CHANNELS-1:0] O_PENDING,
	output logic [CHANNELS-1:0] O_GRANTED
);

	// module-local since its width follows CHANNELS; one instance per engine, nothing shared
	typedef struct packed {
		css_pkg::css_state_t state;
		logic [2:0] slot;
		logic [CHANNELS-1:0] pending;
		logic [CHANNELS-1:0] granted;
		logic grant;
		logic [CHAN_W-1:0] grant_chan;
	} css_regs_t;

	css_regs_t s_reg;
	css_regs_t s_next;

	logic [CHANNELS-1:0] is_high;
	logic [CHANNELS-1:0] is_mid;
	logic [CHANNELS-1:0] is_low;

	// per-channel level decode; a null channel belongs to no level
	genvar gi;
	generate
		for (gi = 0; gi < CHANNELS; gi++) begin : g_lvl
			assign is_high[gi] = I_CHAN_PRIORITY[2*gi+1 -: 2] == css_pkg::CSS_LVL_HIGH;
			assign is_mid[gi] = I_CHAN_PRIORITY[2*gi+1 -: 2] == css_pkg::CSS_LVL_MID;
			assign is_low[gi] = I_CHAN_PRIORITY[2*gi+1 -: 2] == css_pkg::CSS_LVL_LOW;
		end
	endgenerate

	// lowest set bit wins
	function automatic logic [CHAN_W-1:0] lowest(input logic [CHANNELS-1:0] v);
		logic [CHAN_W-1:0] r;
		r = '0;
		for (int i = CHANNELS - 1; i >= 0; i--) begin
			if (v[i]) begin
				r = CHAN_W'(i);
			end
		end
		return r;
	endfunction

	// assigned level of a slot index 0..6
	function automatic logic [1:0] slot_level(input logic [2:0] sl);
		logic [13:0] tbl;
		tbl = `CSS_SLOT_LEVELS;
		return tbl[{sl, 1'b0} +: `CSS_LEVEL_W];
	endfunction

	logic [CHANNELS-1:0] pend_n;
	logic [CHANNELS-1:0] elig_h;
	logic [CHANNELS-1:0] elig_m;
	logic [CHANNELS-1:0] elig_l;
	logic [CHANNELS-1:0] pick;
	logic [1:0] lvl;

	always_comb begin
		s_next = s_reg;
		s_next.grant = 1'b0;
		// new requests win over a clear in the same cycle; priority plays no part here,
		// so requests on disabled channels simply stay pending
		pend_n = (s_reg.pending & ~I_REQ_CLEAR)
			| I_CHAN_EVENT_REQ | I_CODE_REQ | I_HOST_REQ;
		s_next.pending = pend_n;
		elig_h = s_reg.pending & ~s_reg.granted & is_high;
		elig_m = s_reg.pending & ~s_reg.granted & is_mid;
		elig_l = s_reg.pending & ~s_reg.granted & is_low;
		lvl = slot_level(s_reg.slot);
		pick = '0;
		case (lvl)
			css_pkg::CSS_LVL_HIGH: begin
				pick = (elig_h != '0) ? elig_h : (elig_m != '0) ? elig_m : elig_l;
			end
			css_pkg::CSS_LVL_MID: begin
				pick = (elig_m != '0) ? elig_m : (elig_h != '0) ? elig_h : elig_l;
			end
			default: begin
				pick = (elig_l != '0) ? elig_l : (elig_h != '0) ? elig_h : elig_m;
			end
		endcase
		case (s_reg.state)
			css_pkg::CSS_ST_IDLE: begin
				// decisions are made only here, between threads
				if (pick != '0) begin
					s_next.grant = 1'b1;
					s_next.grant_chan = lowest(pick);
					s_next.granted[lowest(pick)] = 1'b1;
					// passed or not, the sequence steps to the next slot
					s_next.slot = (s_reg.slot == `CSS_SLOT_LAST) ? `CSS_SLOT_FIRST
						: 3'(s_reg.slot + 3'h1);
					s_next.state = css_pkg::CSS_ST_BUSY;
				end else begin
					s_next.slot = `CSS_SLOT_FIRST;
				end
			end
			css_pkg::CSS_ST_BUSY: begin
				// a priority change does not stop the thread; only its end does
				if (I_THREAD_END) begin
					s_next.state = css_pkg::CSS_ST_IDLE;
					// a level whose every requester holds a grant bit starts afresh
					if (((pend_n & is_high) & ~s_reg.granted) == '0) begin
						s_next.granted = s_next.granted & ~is_high;
					end
					if (((pend_n & is_mid) & ~s_reg.granted) == '0) begin
						s_next.granted = s_next.granted & ~is_mid;
					end
					if (((pend_n & is_low) & ~s_reg.granted) == '0) begin
						s_next.granted = s_next.granted & ~is_low;
					end
				end
			end
			default: begin
				s_next.state = css_pkg::CSS_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			s_reg.state <= css_pkg::CSS_ST_IDLE;
			s_reg.slot <= `CSS_SLOT_FIRST;
			s_reg.pending <= {CHANNELS{`CSS_PENDING_RST}};
			s_reg.granted <= {CHANNELS{`CSS_GRANTED_RST}};
			s_reg.grant <= 1'b0;
			s_reg.grant_chan <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign O_GRANT = s_reg.grant;
	assign O_GRANT_CHAN = s_reg.grant_chan;
	assign O_BUSY = s_reg.state == css_pkg::CSS_ST_BUSY;
	assign O_SLOT = s_reg.slot;
	assign O_PENDING = s_reg.pending;
	assign O_GRANTED = s_reg.granted;

endmodule

`default_nettype wire

// *** bench/css_scheduler_chk.sv ***
`timescale 1ns/1ns
`default_nettype none
module css_scheduler_chk #(
	parameter int CHANNELS = 32,
	parameter int CHAN_W = 5
) (
	input wire logic I_CLK,
	input wire logic I_ARST_N,
	input wire logic [2*CHANNELS-1:0] I_CHAN_PRIORITY,
	input wire logic [CHANNELS-1:0] I_HOST_REQ,
	input wire logic I_THREAD_END,
	input wire logic O_GRANT,
	input wire logic [CHAN_W-1:0] O_GRANT_CHAN,
	input wire logic O_BUSY,
	input wire logic [2:0] O_SLOT,
	input wire logic [CHANNELS-1:0] O_PENDING,
	input wire logic [CHANNELS-1:0] O_GRANTED
);
	default clocking @(posedge I_CLK); endclocking
	default disable iff (!I_ARST_N);
	sequence s_end;
		O_BUSY && I_THREAD_END;
	endsequence
	sequence s_idle;
		!O_BUSY && !O_GRANT && O_PENDING == '0;
	endsequence
	a_grant_pulse: assert property (O_GRANT |=> !O_GRANT) else $error("long strobe");
	a_grant_bit: assert property (O_GRANT |-> O_GRANTED[O_GRANT_CHAN] && O_BUSY)
		else $error("grant bit unset");
	a_only_eligible: assert property (O_GRANT |->
		(($past(O_PENDING & ~O_GRANTED) >> O_GRANT_CHAN) & 1) == 1) else $error("bad grant");
	a_grant_enabled: assert property (O_GRANT |->
		(($past(I_CHAN_PRIORITY) >> {O_GRANT_CHAN, 1'b0}) & 2'h3) != 0) else $error("disabled grant");
	a_slot_step: assert property (O_GRANT |->
		O_SLOT == ($past(O_SLOT) == 3'h6 ? 3'h0 : $past(O_SLOT) + 3'h1)) else $error("slot step");
	a_idle_home: assert property (s_idle |=> O_SLOT == 3'h0) else $error("no slot reset");
	a_thread_hold: assert property (O_BUSY && !I_THREAD_END |=> O_BUSY && !O_GRANT)
		else $error("preempted");
	a_end_gap: assert property (s_end |=> !O_BUSY && !O_GRANT) else $error("end gap");
	a_host_set: assert property (I_HOST_REQ != '0 |=>
		(O_PENDING & $past(I_HOST_REQ)) == $past(I_HOST_REQ)) else $error("request lost");
endmodule
bind css_scheduler css_scheduler_chk #(.CHANNELS(CHANNELS), .CHAN_W(CHAN_W)) chk_u (
	.I_CLK(I_CLK), .I_ARST_N(I_ARST_N), .I_HOST_REQ(I_HOST_REQ), .I_THREAD_END(I_THREAD_END),
	.I_CHAN_PRIORITY(I_CHAN_PRIORITY),
	.O_GRANT(O_GRANT), .O_GRANT_CHAN(O_GRANT_CHAN), .O_BUSY(O_BUSY), .O_SLOT(O_SLOT),
	.O_PENDING(O_PENDING), .O_GRANTED(O_GRANTED));
`default_nettype wire

// *** bench/css_engine_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module css_engine_model (
	input wire logic i_clk,
	input wire logic i_grant,
	input wire logic [1:0] i_chan,
	input wire logic [3:0] i_len,
	output logic o_end,
	output logic [3:0] o_clear
);
	initial begin
		o_end = 1'b0;
		o_clear = 4'h0;
		forever begin
			@(posedge i_clk);
			if (i_grant === 1'b1) begin
				// thread length varies, so slots vary too
				repeat (i_len) @(posedge i_clk);
				#1 o_end = 1'b1;
				o_clear = 4'h1 << i_chan;
				@(posedge i_clk);
				#1 o_end = 1'b0;
				o_clear = 4'h0;
			end
		end
	end
endmodule
`default_nettype wire

// *** bench/css_scheduler_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module css_scheduler_tb;
	logic clk = 0, rst_n = 0, t_end, grant, busy;
	logic [7:0] prio = 8'h00;
	logic [3:0] ev = 4'h0, cd = 4'h0, hr = 4'h0, clr, pend, gnt, len = 4'h1;
	logic [1:0] gch, exp_q[$];
	logic [2:0] slot;
	int err_total = 0, samples_checked = 0, cyc = 0, seed = 32'hfb1bcbcc;
	initial forever #5 clk = ~clk;
	css_scheduler #(.CHANNELS(4)) dut_u (.I_CLK(clk), .I_ARST_N(rst_n), .I_CHAN_PRIORITY(prio),
		.I_CHAN_EVENT_REQ(ev), .I_CODE_REQ(cd), .I_HOST_REQ(hr), .I_REQ_CLEAR(clr),
		.I_THREAD_END(t_end), .O_GRANT(grant), .O_GRANT_CHAN(gch), .O_BUSY(busy),
		.O_SLOT(slot), .O_PENDING(pend), .O_GRANTED(gnt));
	css_engine_model eng_u (.i_clk(clk), .i_grant(grant), .i_chan(gch), .i_len(len),
		.o_end(t_end), .o_clear(clr));
	task automatic chk(input logic [3:0] got, input logic [3:0] want);
		samples_checked++;
		if (got !== want) begin
			err_total++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, got, want);
		end
	endtask
	// a grant with no note queued is an unexpected grant, not a default compare
	task automatic chk_grant(input logic [1:0] got);
		logic [1:0] want;
		samples_checked++;
		if (exp_q.size() == 0) begin
			err_total++;
			$display("CHECK FAILED at %0t: unexpected grant %h", $time, got);
		end else begin
			want = exp_q.pop_front();
			if (got !== want) begin
				err_total++;
				$display("CHECK FAILED at %0t: grant %h want %h", $time, got, want);
			end
		end
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic req(input logic [3:0] m);
		int s;
		s = $unsigned($random(seed)) % 3;
		len = 4'($unsigned($random(seed)) % 4);
		if (s == 0) ev = m;
		else if (s == 1) cd = m;
		else hr = m;
		@(posedge clk);
		#1 ev = 4'h0;
		cd = 4'h0;
		hr = 4'h0;
	endtask
	// waits out the last thread; slot must be home once idle
	task automatic drain(input logic [3:0] p, input logic [3:0] g);
		wait (exp_q.size() == 0 && busy === 1'b0);
		repeat (2) @(posedge clk);
		#1 chk(pend, p);
		chk(gnt, g);
		chk({1'b0, slot}, 4'h0);
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc > 3000) begin
			err_total++;
			conclude();
		end else if (grant === 1'b1) begin
			chk_grant(gch);
		end
	end
	initial begin
		@(posedge clk);
		// requests during reset must not survive it
		#1 hr = 4'hf;
		repeat (4) @(posedge clk);
		#1 rst_n = 1;
		chk(pend, 4'h0);
		chk(gnt, 4'h0);
		exp_q = '{2'h0, 2'h2, 2'h1, 2'h3};
		@(posedge clk);
		#1 hr = 4'h0;
		prio = 8'haf;
		drain(4'h0, 4'h0);
		$display("slot order test done");
		prio = 8'h01;
		exp_q = '{2'h0};
		req(4'h3);
		drain(4'h2, 4'h0);
		prio = 8'h05;
		exp_q = '{2'h1};
		drain(4'h0, 4'h0);
		$display("disable test done");
		// ch0 keeps requesting while granted; grants fill all seven slots and the slot wraps
		prio = 8'h6f;
		exp_q = '{2'h0, 2'h2, 2'h1, 2'h3, 2'h0, 2'h0, 2'h0};
		ev = 4'h1;
		cd = 4'he;
		@(posedge clk);
		#1 cd = 4'h0;
		wait (exp_q.size() == 0);
		#1 ev = 4'h0;
		drain(4'h0, 4'h0);
		$display("slot wrap test done");
		prio = 8'h00;
		req(4'h4);
		rst_n = 0;
		repeat (2) @(posedge clk);
		#1 rst_n = 1;
		repeat (2) @(posedge clk);
		#1 chk(pend, 4'h0);
		chk(gnt, 4'h0);
		chk({1'b0, slot}, 4'h0);
		$display("reset test done");
		conclude();
	end
endmodule
`default_nettype wire
